// ### test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpw_pkg::*;
  logic clock = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, timer_out;
  logic timer_out_en, irq;
  logic [1:0] bresp, rresp;
  logic [15:0] per_len, high_len, m, l, s = 16'h0032;
  logic [33:0] q[$];
  int n_mismatch = 0, cmp_count = 0;
  always #4 clock = ~clock;
  tpw_top DUT (.*);
  tpw_pin_model u_pin (.clock(clock), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .per_len(per_len), .high_len(high_len));
  function logic [15:0] xs();
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction : xs
  task chk(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = resp_okay);
    q.push_back({r, 32'h0});
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    fork
      begin do @(posedge clock); while (!awready); awvalid <= 0; end
      begin do @(posedge clock); while (!wready); wvalid <= 0; end
    join
    @(posedge clock);
    bready <= 1;
    do @(posedge clock); while (!bvalid);
    bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    arvalid <= 1;
    araddr <= a;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    @(posedge clock);
    rready <= 1;
    do @(posedge clock); while (!rvalid);
    rready <= 0;
  endtask : rd
  // Responses are matched against the oldest note
  always @(posedge clock) begin
    if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
    else if (bvalid && bready) chk({bresp, 32'h0}, q.pop_front());
  end
  task summarize();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), {resp_okay, (i == 3) ? 32'hFFFF : 32'h0});
    end
    rd(8'h18, {resp_slverr, 32'h0});
    for (int k = 0; k < 4; k++) begin
      m = 16'h4 + xs() % 8;
      l = m + 16'h2 + xs() % 8;
      wr(ctrl_addr, 32'((k / 2) * 16 + (k % 2) * 2));
      wr(count_addr, 32'(k > 1 ? 1 : 3));
      wr(match_addr, 32'(m));
      wr(reload_addr, 32'(l));
      wr(mask_addr, 32'(k % 2));
      wr(ctrl_addr, 32'((k / 2) * 16 + (k % 2) * 2 + 1));
      repeat (6 * l) @(posedge clock);
      chk(34'(per_len), 34'(l << (k / 2)));
      chk(34'(high_len), 34'((k % 2 ? m : l - m) << (k / 2)));
      chk(34'(irq), 34'(k % 2));
      wr(ctrl_addr, 32'h0);
      rd(status_addr, {resp_okay, 32'h1});
      wr(status_addr, 32'h1);
      rd(status_addr, {resp_okay, 32'h0});
      chk(34'(irq), 34'h0);
    end
    wr(count_addr, 32'h7);
    repeat (20) @(posedge clock);
    rd(count_addr, {resp_okay, 32'h7});
    wstrb <= 4'h2;
    wr(match_addr, 32'h0000AB00);
    wstrb <= 4'hF;
    rd(match_addr, {resp_okay, 16'h0, 8'hAB, m[7:0]});
    wr(8'h18, 32'h5, resp_slverr);
    summarize();
  end
endmodule : tb_top

// ### test/tpw_pin_model.sv
module tpw_pin_model (
  // Pin side
  input wire logic clock,
  input wire logic timer_out,
  input wire logic timer_out_en,
  // Measured waveform
  output logic [15:0] per_len,
  output logic [15:0] high_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cyc = 16'h0;
  logic [15:0] hc = 16'h0;
  logic prev = 1'b0;
  // Pin is pulled low while not driven
  wire pin = timer_out_en & timer_out;
  always @(posedge clock) begin
    prev <= pin;
    if (pin && !prev) begin
      per_len <= cyc;
      high_len <= hc;
      cyc <= 16'h1;
      hc <= 16'h1;
    end else begin
      cyc <= cyc + 16'h1;
      hc <= hc + 16'(pin);
    end
  end
endmodule : tpw_pin_model

// ### test/tpw_top_assertions.sv
module tpw_top_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write channels
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Pin and interrupt
  input wire logic timer_out_en,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpw_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_w_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_w_answer: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("no write response");
  a_b_stands: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_b_release: assert property (
    bvalid && bready |=> !bvalid && awready)
    else $error("write channel not freed");
  a_r_stands: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_r_release: assert property (
    rvalid && rready |=> !rvalid && arready)
    else $error("read channel not freed");
  a_rd_mapped: assert property (
    arvalid && arready && araddr <= 8'h14 && araddr[1:0] == 2'h0
    |=> rvalid && rresp == resp_okay)
    else $error("mapped read not okay");
  a_rd_unmapped: assert property (
    arvalid && arready && araddr > 8'h14
    |=> rvalid && rresp == resp_slverr && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property (
    $fell(reset) |-> !timer_out_en && !irq)
    else $error("pin or interrupt active after reset");
endmodule : tpw_top_assertions

bind tpw_top tpw_top_assertions u_chk (.*);

// ### verilog/tpw_cfg_if.sv
interface tpw_cfg_if;
  logic enable;
  logic polarity;
  logic [2:0] prescale;
  logic [15:0] match;
  logic [15:0] reload;
  logic load_strobe;
  logic [15:0] load_value;
  logic [15:0] count;
  logic period_end;
  logic pwm_out;
  modport regs (output enable, polarity, prescale, match, reload,
    load_strobe, load_value, input count, period_end, pwm_out);
  modport core (input enable, polarity, prescale, match, reload,
    load_strobe, load_value, output count, period_end, pwm_out);
endinterface : tpw_cfg_if

// ### verilog/tpw_core.sv
module tpw_core (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration and state
  tpw_cfg_if.core cfg
);
  import tpw_pkg::*;

  logic [7:0] prescale_count;
  logic [7:0] next_prescale_count;
  logic [7:0] prescale_limit;
  wire tick;
  wire at_match;
  wire at_reload;

  // Divide by 2^prescale before each count step
  assign prescale_limit = 8'((8'h01 << cfg.prescale) - 8'h01);
  assign tick = cfg.enable && (prescale_count == prescale_limit);
  assign next_prescale_count = tick ? 8'h00 : 8'(prescale_count + 8'h01);
  assign at_match = cfg.count == cfg.match;
  assign at_reload = cfg.count == cfg.reload;

  always_ff @(posedge clock) begin
    if (reset || !cfg.enable) begin
      prescale_count <= 8'h00;
    end else begin
      prescale_count <= next_prescale_count;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg.count <= count_reset;
      cfg.pwm_out <= 1'b0;
      cfg.period_end <= 1'b0;
    end else begin
      cfg.period_end <= tick && at_reload;
      if (cfg.load_strobe) begin
        cfg.count <= cfg.load_value;
      end else if (tick && at_reload) begin
        cfg.count <= count_restart;
      end else if (tick) begin
        cfg.count <= 16'(cfg.count + 16'h0001);
      end
      if (!cfg.enable || (tick && at_reload)) begin
        cfg.pwm_out <= cfg.polarity;
      end else if (tick && at_match) begin
        cfg.pwm_out <= ~cfg.polarity;
      end
    end
  end
endmodule : tpw_core

// ### verilog/tpw_pkg.sv
package tpw_pkg;
  // Register byte addresses
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] count_addr = 8'h04;
  localparam logic [7:0] match_addr = 8'h08;
  localparam logic [7:0] reload_addr = 8'h0C;
  localparam logic [7:0] status_addr = 8'h10;
  localparam logic [7:0] mask_addr = 8'h14;
  // Control field positions
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_polarity_bit = 1;
  localparam int ctrl_prescale_lsb = 4;
  localparam int prescale_width = 3;
  // Reset and restart values, response codes
  localparam logic [15:0] count_restart = 16'h0001;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] match_reset = 16'h0000;
  localparam logic [15:0] reload_reset = 16'hFFFF;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic mask_reset = 1'b0;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : tpw_pkg

// ### verilog/tpw_top.sv
module tpw_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Timer output pin and interrupt
  output logic timer_out,
  output logic timer_out_en,
  output logic irq
);
  import tpw_pkg::*;

  tpw_cfg_if cfg ();

  logic [7:0] ctrl;
  logic [15:0] match;
  logic [15:0] reload;
  logic status;
  logic mask;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] next_rdata;
  logic next_rerr;

  wire [7:0] waddr = aw_held ? aw_addr_q : awaddr;
  wire [31:0] wdat = w_held ? w_data_q : wdata;
  wire [3:0] wstb = w_held ? w_strb_q : wstrb;
  wire have_aw = aw_held || awvalid;
  wire have_w = w_held || wvalid;
  wire do_write = have_aw && have_w && !bvalid;
  wire do_read = arvalid && !rvalid;
  wire wr_ctrl = do_write && waddr == ctrl_addr && wstb[0];
  wire wr_count = do_write && waddr == count_addr;
  wire wr_match = do_write && waddr == match_addr;
  wire wr_reload = do_write && waddr == reload_addr;
  wire wr_status = do_write && waddr == status_addr && wstb[0];
  wire wr_mask = do_write && waddr == mask_addr && wstb[0];
  wire w_mapped = waddr == ctrl_addr || wr_count || wr_match ||
    wr_reload || waddr == status_addr || waddr == mask_addr;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire status_clear = wr_status && wdat[0];
  wire next_status = cfg.period_end || (status && !status_clear);
  // Byte-lane merge for the 16-bit registers; unstrobed lanes keep value
  logic [15:0] count_merged;
  logic [15:0] match_merged;
  logic [15:0] reload_merged;
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    assign count_merged[8*lane +: 8] = wstb[lane] ?
      wdat[8*lane +: 8] : cfg.count[8*lane +: 8];
    assign match_merged[8*lane +: 8] = wstb[lane] ?
      wdat[8*lane +: 8] : match[8*lane +: 8];
    assign reload_merged[8*lane +: 8] = wstb[lane] ?
      wdat[8*lane +: 8] : reload[8*lane +: 8];
  end

  assign cfg.enable = ctrl[ctrl_enable_bit];
  assign cfg.polarity = ctrl[ctrl_polarity_bit];
  assign cfg.prescale = ctrl[ctrl_prescale_lsb +: prescale_width];
  assign cfg.match = match;
  assign cfg.reload = reload;
  assign cfg.load_strobe = wr_count;
  assign cfg.load_value = count_merged;

  tpw_core core (
    .clock(clock),
    .reset(reset),
    .cfg(cfg)
  );

  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    unique case (araddr)
      ctrl_addr: next_rdata = {24'h000000, ctrl};
      count_addr: next_rdata = {16'h0000, cfg.count};
      match_addr: next_rdata = {16'h0000, match};
      reload_addr: next_rdata = {16'h0000, reload};
      status_addr: next_rdata = {31'h00000000, status};
      mask_addr: next_rdata = {31'h00000000, mask};
      default: next_rerr = 1'b1;
    endcase
  end

  // Write channel capture; either channel may arrive first
  always_ff @(posedge clock) begin
    if (reset || do_write) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
      end
      if (w_take) begin
        w_held <= 1'b1;
      end
    end
    if (aw_take) begin
      aw_addr_q <= awaddr;
    end
    if (w_take) begin
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end else if (do_write) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b1;
      bresp <= w_mapped ? resp_okay : resp_slverr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
    end else begin
      if (aw_take) begin
        awready <= 1'b0;
      end
      if (w_take) begin
        wready <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= resp_okay;
    end else if (do_read) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rerr ? resp_slverr : resp_okay;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= ctrl_reset;
      match <= match_reset;
      reload <= reload_reset;
      mask <= mask_reset;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdat[7:0];
      end
      if (wr_match) begin
        match <= match_merged;
      end
      if (wr_reload) begin
        reload <= reload_merged;
      end
      if (wr_mask) begin
        mask <= wdat[0];
      end
    end
  end

  // Period-end event is sticky; a new event wins over a write-one clear
  always_ff @(posedge clock) begin
    if (reset) begin
      status <= 1'b0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_status && mask;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      timer_out <= 1'b0;
      timer_out_en <= 1'b0;
    end else begin
      timer_out <= cfg.pwm_out;
      timer_out_en <= cfg.enable;
    end
  end
endmodule : tpw_top
